// >>> logic/pot_pkg.sv
// Shared constants and types for the stereo log potentiometer serial link.
package pot_pkg;
	localparam int         CLK_PERIOD_NS  = 25;
	localparam int         SCL_PERIOD_NS  = 2500;
	localparam int         QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
		/ (4 * CLK_PERIOD_NS);
	localparam int         BYTE_BITS      = 8;
	localparam int         NUM_TAPS       = 32;
	localparam logic [4:0] MUTE_POS       = 5'h00;
	localparam logic [4:0] TOP_POS        = 5'h1F;
	localparam logic [7:0] MUTE_DB        = 8'hA4;
	localparam logic [3:0] OP_WRITE       = 4'hA;
	localparam logic [3:0] OP_STEP        = 4'h2;
	localparam int         ADR_TYPE_LSB   = 3;
	localparam int         ADR_HI_BIT     = 2;
	localparam int         ADR_LO_BIT     = 1;
	localparam int         ADR_RW_BIT     = 0;
	localparam int         INS_OP_LSB     = 4;
	localparam int         INS_ZERO_BIT   = 3;
	localparam int         INS_ZC_BIT     = 2;
	localparam int         INS_RIGHT_BIT  = 1;
	localparam int         INS_LEFT_BIT   = 0;
	// Device type pattern in the upper five slave-byte bits; the value is arbitrary.
	localparam logic [4:0] TYPE_ID_DEFAULT = 5'h1A;

	typedef enum logic [1:0] {
		CMD_WRITE = 2'h0,
		CMD_STEP  = 2'h1,
		CMD_READ  = 2'h2
	} cmd_t;
endpackage : pot_pkg

// >>> logic/pot_link_if.sv
// Two-wire link between the bus master and the potentiometer controller.
`timescale 1ns/100ps
interface pot_link_if;
	logic scl;        // Serial clock, driven by the master only.
	logic hostSdaOe;  // Master pulls data low.
	logic devSdaOe;   // Device pulls data low.
	logic sda;        // Resolved wired-AND data level with pull-up.

	assign sda = ~(hostSdaOe | devSdaOe);

	modport host   (output scl, output hostSdaOe, input sda);
	modport device (input scl, input sda, output devSdaOe);
endinterface : pot_link_if

// >>> logic/tap_decoder.sv
// One-hot tap select and attenuation figure for one wiper position.
`timescale 1ns/100ps
module tap_decoder (
	input  wire logic        clk,      // System clock.
	input  wire logic        resetn,   // Asynchronous reset, active low.
	input  wire logic        ce,       // Clock enable.
	input  wire logic [4:0]  pos,      // Wiper position.
	output logic [31:0]      tapSel,   // One-hot tap switch select.
	output logic [7:0]       attenDb   // Signed attenuation in dB.
);
	function automatic logic [7:0] dbOf(input logic [4:0] n);
		logic [7:0] w;
		w = {3'h0, n};
		if (n >= 5'h14)
			return 8'(w - 8'h1F);
		else if (n >= 5'h0A)
			return 8'(2 * w - 8'h33);
		else if (n >= 5'h05)
			return 8'(3 * w - 8'h3D);
		else if (n >= 5'h01)
			return 8'(4 * w - 8'h42);
		else
			return pot_pkg::MUTE_DB;
	endfunction : dbOf

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tapSel  <= 32'h0000_0001;
			attenDb <= pot_pkg::MUTE_DB;
		end else if (ce) begin
			tapSel  <= 32'h0000_0001 << pos; // R12 R13
			attenDb <= dbOf(pos); // R14
		end
	end
endmodule : tap_decoder

// >>> logic/pot_device.sv
// Serial slave controller holding the two wiper positions of the stereo pot.
// Operation
// R1 - Answer only matching type and strap address
// R2 - Floating strap pin reads as zero
// R3 - Master reads only with one device present
// R4 - Data line only pulled low or released
// R5 - Data changes only while clock is low
// R6 - Watch lines always; wait for start
// R7 - Stop ends every transfer; device detects it
// R8 - Transmitter releases; receiver acks ninth clock
// R9 - Acknowledge address, instruction and data bytes
// R10 - Bad address or command: no ack, idle
// R11 - Master clocks; device never drives clock
// R12 - One-hot select: one tap per channel
// R13 - Thirty-two taps, five-bit position 0..31
// R14 - Piecewise dB per tap, tap 0 mute
// R15 - Both wipers start at mute
// R16 - Zero-cross mode defers change to crossing
// R17 - Left, right or both channels targetable
// R18 - Instruction byte: opcode, zero, zc, sides
// R19 - Step pulses move wiper up or down
// R20 - Read returns left then right positions
// R21 - Write is three bytes, both four
// R22 - Stepping saturates at both ends
// R23 - Most significant bit first, sample rising
`timescale 1ns/100ps
module pot_device #(
	parameter logic [4:0] TYPE_ID = pot_pkg::TYPE_ID_DEFAULT  // Type pattern; arbitrary.
) (
	input  wire logic        clk,          // System clock.
	input  wire logic        resetn,       // Asynchronous reset, active low.
	input  wire logic        ce,           // Clock enable.
	pot_link_if.device       link,         // Two-wire link.
	input  wire logic        addrStrapHi,  // Upper address strap pin.
	input  wire logic        addrStrapLo,  // Lower address strap pin.
	input  wire logic        zeroCross,    // Zero-crossing comparator level.
	output logic [31:0]      tapSelLeft,   // Left one-hot tap select.
	output logic [31:0]      tapSelRight,  // Right one-hot tap select.
	output logic [7:0]       attenLeft,    // Left attenuation, signed dB.
	output logic [7:0]       attenRight,   // Right attenuation, signed dB.
	output logic [4:0]       wiperLeft,    // Left wiper position.
	output logic [4:0]       wiperRight    // Right wiper position.
);
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_INSTR = 6'h04,
		ST_DATA  = 6'h08,
		ST_STEP  = 6'h10,
		ST_READ  = 6'h20
	} state_t;

	logic [1:0]       sclSync_r, sdaSync_r, hiSync_r, loSync_r, zcSync_r;
	logic [1:0]       selMask_r, reqMask_r, pendValid_r, myAddr;
	logic             sclPrev_r, sdaPrev_r, zcPrev_r, ninth_r, masterAck_r, readRight_r;
	logic             sdaOe_r, zcMode_r, secondData_r, stepArmed_r, wrStb_r, stepStb_r;
	logic             stepUp_r, reqZc_r, byteOk;
	logic             sclS, sdaS, startEv, stopEv, sclRise, sclFall, zcPulse;
	state_t           state_r, nxtState_r, byteNxt;
	logic [3:0]       bitCnt_r;
	logic [7:0]       rxByte_r, txByte_r;
	logic [4:0]       reqPos_r;
	logic [1:0][4:0]  wiper_r, pendPos_r;
	logic [1:0][31:0] tapSel;
	logic [1:0][7:0]  atten;

	assign sclS    = sclSync_r[1];
	assign sdaS    = sdaSync_r[1];
	assign startEv = sclS & sclPrev_r & sdaPrev_r & ~sdaS; // R6
	assign stopEv  = sclS & sclPrev_r & ~sdaPrev_r & sdaS; // R7
	assign sclRise = sclS & ~sclPrev_r;
	assign sclFall = ~sclS & sclPrev_r;
	assign zcPulse = zcSync_r[1] ^ zcPrev_r;
	// The strap pads carry pull-downs, so an open pin arrives here as zero.
	assign myAddr  = {hiSync_r[1], loSync_r[1]}; // R2

	// Only a low pull or a release ever reaches the data line.
	assign link.devSdaOe = sdaOe_r; // R4 R11

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			hiSync_r  <= 2'h0;
			loSync_r  <= 2'h0;
			zcSync_r  <= 2'h0;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			zcPrev_r  <= 1'b0;
		end else if (ce) begin
			sclSync_r <= {sclSync_r[0], link.scl};
			sdaSync_r <= {sdaSync_r[0], link.sda};
			hiSync_r  <= {hiSync_r[0], addrStrapHi};
			loSync_r  <= {loSync_r[0], addrStrapLo};
			zcSync_r  <= {zcSync_r[0], zeroCross};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
			zcPrev_r  <= zcSync_r[1];
		end
	end

	always_comb begin
		byteOk  = 1'b0;
		byteNxt = ST_IDLE;
		unique case (state_r)
			ST_ADDR: begin
				if (rxByte_r[7:pot_pkg::ADR_TYPE_LSB] == TYPE_ID &&
					rxByte_r[pot_pkg::ADR_HI_BIT:pot_pkg::ADR_LO_BIT] == myAddr) begin // R1
					byteOk  = 1'b1;
					byteNxt = rxByte_r[pot_pkg::ADR_RW_BIT] ? ST_READ : ST_INSTR; // R20
				end
			end
			ST_INSTR: begin
				if (!rxByte_r[pot_pkg::INS_ZERO_BIT] && rxByte_r[1:0] != 2'h0) begin // R18
					if (rxByte_r[7:pot_pkg::INS_OP_LSB] == pot_pkg::OP_WRITE) begin
						byteOk  = 1'b1;
						byteNxt = ST_DATA;
					end else if (rxByte_r[7:pot_pkg::INS_OP_LSB] == pot_pkg::OP_STEP) begin
						byteOk  = 1'b1;
						byteNxt = ST_STEP;
					end
				end
			end
			ST_DATA: begin
				byteOk  = 1'b1;
				byteNxt = (selMask_r == 2'h3 && !secondData_r) ? ST_DATA : ST_IDLE; // R21
			end
			default: byteOk = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r      <= ST_IDLE;
			nxtState_r   <= ST_IDLE;
			bitCnt_r     <= 4'h0;
			ninth_r      <= 1'b0;
			masterAck_r  <= 1'b0;
			readRight_r  <= 1'b0;
			rxByte_r     <= 8'h00;
			txByte_r     <= 8'h00;
			sdaOe_r      <= 1'b0;
			selMask_r    <= 2'h0;
			zcMode_r     <= 1'b0;
			secondData_r <= 1'b0;
			stepArmed_r  <= 1'b0;
			wrStb_r      <= 1'b0;
			stepStb_r    <= 1'b0;
			stepUp_r     <= 1'b0;
			reqMask_r    <= 2'h0;
			reqPos_r     <= 5'h00;
			reqZc_r      <= 1'b0;
		end else if (ce) begin
			wrStb_r   <= 1'b0;
			stepStb_r <= 1'b0;
			if (startEv || stopEv) begin
				state_r     <= startEv ? ST_ADDR : ST_IDLE; // R6 R7
				bitCnt_r    <= 4'h0;
				ninth_r     <= 1'b0;
				sdaOe_r     <= 1'b0;
				stepArmed_r <= 1'b0;
			end else if (sclRise && state_r == ST_STEP) begin
				stepArmed_r <= 1'b1; // R19
				stepUp_r    <= sdaS;
			end else if (sclRise && state_r != ST_IDLE) begin
				if (bitCnt_r < 4'(pot_pkg::BYTE_BITS)) begin
					rxByte_r <= {rxByte_r[6:0], sdaS}; // R23
					bitCnt_r <= 4'(bitCnt_r + 4'h1);
				end else begin
					ninth_r     <= 1'b1;
					masterAck_r <= ~sdaS;
				end
			end else if (sclFall && state_r == ST_STEP) begin
				// A pulse counts only once its clock falls, so the stop clock never steps.
				if (stepArmed_r) begin
					stepStb_r <= 1'b1; // R19
					reqMask_r <= selMask_r; // R17
					reqZc_r   <= zcMode_r;
				end
				stepArmed_r <= 1'b0;
			end else if (sclFall && state_r != ST_IDLE) begin
				if (ninth_r) begin
					ninth_r  <= 1'b0;
					bitCnt_r <= 4'h0;
					if (state_r == ST_READ && (readRight_r || !masterAck_r)) begin
						state_r <= ST_IDLE;
						sdaOe_r <= 1'b0;
					end else if (state_r == ST_READ) begin
						txByte_r    <= {3'h0, wiper_r[1]}; // R20
						sdaOe_r     <= 1'b1;
						readRight_r <= 1'b1;
					end else begin
						state_r <= nxtState_r;
						if (nxtState_r == ST_READ) begin
							txByte_r    <= {3'h0, wiper_r[0]}; // R20
							sdaOe_r     <= 1'b1;
							readRight_r <= 1'b0;
						end else begin
							sdaOe_r <= 1'b0; // R8
						end
					end
				end else if (bitCnt_r == 4'(pot_pkg::BYTE_BITS)) begin
					if (state_r == ST_READ) begin
						sdaOe_r <= 1'b0; // R8
					end else begin
						sdaOe_r    <= byteOk; // R9 R5
						nxtState_r <= byteNxt;
						if (!byteOk)
							state_r <= ST_IDLE; // R10
						if (state_r == ST_INSTR) begin
							selMask_r    <= rxByte_r[pot_pkg::INS_RIGHT_BIT:pot_pkg::INS_LEFT_BIT];
							zcMode_r     <= rxByte_r[pot_pkg::INS_ZC_BIT]; // R16
							secondData_r <= 1'b0;
						end
						if (state_r == ST_DATA) begin
							wrStb_r  <= 1'b1;
							reqPos_r <= rxByte_r[4:0];
							reqZc_r  <= zcMode_r;
							if (selMask_r == 2'h3) begin
								reqMask_r    <= secondData_r ? 2'h2 : 2'h1; // R21 R17
								secondData_r <= 1'b1;
							end else begin
								reqMask_r <= selMask_r; // R17
							end
						end
					end
				end else if (state_r == ST_READ && bitCnt_r != 4'h0) begin
					sdaOe_r <= ~txByte_r[3'(3'h7 - bitCnt_r[2:0])]; // R23 R5
				end
			end
		end
	end

	function automatic logic [4:0] satStep(input logic [4:0] p, input logic up);
		if (up)
			return (p == pot_pkg::TOP_POS) ? p : 5'(p + 5'h01);
		else
			return (p == pot_pkg::MUTE_POS) ? p : 5'(p - 5'h01);
	endfunction : satStep

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wiper_r     <= {2{pot_pkg::MUTE_POS}}; // R15
			pendPos_r   <= {2{pot_pkg::MUTE_POS}};
			pendValid_r <= 2'h0;
		end else if (ce) begin
			for (int c = 0; c < 2; c++) begin
				logic [4:0] base;
				logic [4:0] target;
				logic       hit;
				base   = pendValid_r[c] ? pendPos_r[c] : wiper_r[c];
				target = wrStb_r ? reqPos_r : satStep(base, stepUp_r); // R22
				hit    = (wrStb_r | stepStb_r) & reqMask_r[c];
				if (hit && (!reqZc_r || zcPulse)) begin
					wiper_r[c]     <= target;
					pendValid_r[c] <= 1'b0;
				end else if (hit) begin
					pendPos_r[c]   <= target; // R16
					pendValid_r[c] <= 1'b1;
				end else if (pendValid_r[c] && zcPulse) begin
					wiper_r[c]     <= pendPos_r[c]; // R16
					pendValid_r[c] <= 1'b0;
				end
			end
		end
	end

	for (genvar c = 0; c < 2; c++) begin : gChan
		tap_decoder uDec (
			.clk     (clk),
			.resetn  (resetn),
			.ce      (ce),
			.pos     (wiper_r[c]),
			.tapSel  (tapSel[c]),
			.attenDb (atten[c])
		);
	end

	assign tapSelLeft  = tapSel[0];
	assign tapSelRight = tapSel[1];
	assign attenLeft   = atten[0];
	assign attenRight  = atten[1];
	assign wiperLeft   = wiper_r[0];
	assign wiperRight  = wiper_r[1];
endmodule : pot_device

// >>> logic/pot_host.sv
// Two-wire bus master that issues write, step and read commands to the pot.
`timescale 1ns/100ps
module pot_host #(
	parameter int         QUARTER = pot_pkg::QUARTER_CYCLES,   // Cycles per quarter bit.
	parameter logic [4:0] TYPE_ID = pot_pkg::TYPE_ID_DEFAULT   // Type pattern; arbitrary.
) (
	input  wire logic          clk,       // System clock.
	input  wire logic          resetn,    // Asynchronous reset, active low.
	input  wire logic          ce,        // Clock enable.
	pot_link_if.host           link,      // Two-wire link.
	input  wire logic          cmdValid,  // Command request.
	output logic               cmdReady,  // Ready to take a command.
	input  wire pot_pkg::cmd_t cmdKind,   // Write, step or read.
	input  wire logic [1:0]    cmdAddr,   // Strap address of the target.
	input  wire logic [1:0]    cmdSel,    // Channel select, bit 1 right, bit 0 left.
	input  wire logic          cmdZc,     // Zero-crossing switching.
	input  wire logic [4:0]    cmdLeft,   // Left position; the single-channel value only when the left channel is selected.
	input  wire logic [4:0]    cmdRight,  // Right position.
	input  wire logic [7:0]    cmdSteps,  // Number of step pulses.
	input  wire logic          cmdUp,     // Step direction, high moves up.
	output logic               rspValid,  // Command finished, one cycle.
	output logic               rspNack,   // A byte was not acknowledged.
	output logic [4:0]         rspLeft,   // Left position read back.
	output logic [4:0]         rspRight   // Right position read back.
);
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_XFER  = 5'h04,
		H_STEP  = 5'h08,
		H_STOP  = 5'h10
	} hstate_t;

	hstate_t    state_r;
	logic [15:0] div_r;
	logic [1:0] q_r;
	logic       scl_r;
	logic       sdaOe_r;
	logic [7:0] bytes_r [4];
	logic [2:0] nBytes_r;
	logic [2:0] byteIdx_r;
	logic [3:0] bitIdx_r;
	logic       readMode_r;
	logic [7:0] steps_r;
	logic       up_r;
	logic       nack_r;
	logic [7:0] rxShift_r;
	logic [1:0] sdaSync_r;
	logic       tick;
	logic       rxByte;

	assign tick     = (div_r == 16'(QUARTER - 1));
	assign rxByte   = readMode_r && byteIdx_r != 3'h0;
	assign cmdReady = (state_r == H_IDLE);
	assign link.scl       = scl_r; // R11
	assign link.hostSdaOe = sdaOe_r; // R4

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdaSync_r <= 2'h3;
		end else if (ce) begin
			sdaSync_r <= {sdaSync_r[0], link.sda};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= H_IDLE;
			div_r      <= 16'h0000;
			q_r        <= 2'h0;
			scl_r      <= 1'b1;
			sdaOe_r    <= 1'b0;
			bytes_r    <= '{default: 8'h00};
			nBytes_r   <= 3'h0;
			byteIdx_r  <= 3'h0;
			bitIdx_r   <= 4'h0;
			readMode_r <= 1'b0;
			steps_r    <= 8'h00;
			up_r       <= 1'b0;
			nack_r     <= 1'b0;
			rxShift_r  <= 8'h00;
			rspValid   <= 1'b0;
			rspNack    <= 1'b0;
			rspLeft    <= 5'h00;
			rspRight   <= 5'h00;
		end else if (ce) begin
			rspValid <= 1'b0;
			div_r    <= tick ? 16'h0000 : 16'(div_r + 16'h0001);
			if (state_r == H_IDLE) begin
				div_r <= 16'h0000;
				q_r   <= 2'h0;
				if (cmdValid) begin
					// Reads are only legal with a single device on the bus.
					readMode_r <= (cmdKind == pot_pkg::CMD_READ); // R3
					bytes_r[0] <= {TYPE_ID, cmdAddr, cmdKind == pot_pkg::CMD_READ}; // R1
					bytes_r[1] <= {(cmdKind == pot_pkg::CMD_WRITE) ? pot_pkg::OP_WRITE
						: pot_pkg::OP_STEP, 1'b0, cmdZc, cmdSel}; // R18
					bytes_r[2] <= {3'h0, cmdSel[0] ? cmdLeft : cmdRight};
					bytes_r[3] <= {3'h0, cmdRight};
					unique case (cmdKind)
						pot_pkg::CMD_WRITE: nBytes_r <= (cmdSel == 2'h3) ? 3'h4 : 3'h3; // R21
						pot_pkg::CMD_STEP:  nBytes_r <= 3'h2;
						pot_pkg::CMD_READ:  nBytes_r <= 3'h3; // R20
						default:            nBytes_r <= 3'h2;
					endcase
					steps_r   <= cmdSteps;
					up_r      <= cmdUp;
					nack_r    <= 1'b0;
					byteIdx_r <= 3'h0;
					bitIdx_r  <= 4'h0;
					state_r   <= H_START;
				end
			end else if (tick) begin
				q_r <= 2'(q_r + 2'h1);
				unique case (state_r)
					H_START: begin
						if (q_r == 2'h0) begin
							scl_r   <= 1'b1;
							sdaOe_r <= 1'b0;
						end else if (q_r == 2'h1) begin
							sdaOe_r <= 1'b1; // R6
						end else if (q_r == 2'h2) begin
							scl_r <= 1'b0;
						end else begin
							state_r <= H_XFER;
						end
					end
					H_XFER: begin
						if (q_r == 2'h0) begin
							if (bitIdx_r == 4'(pot_pkg::BYTE_BITS))
								sdaOe_r <= rxByte && byteIdx_r == 3'h1; // R8
							else if (rxByte)
								sdaOe_r <= 1'b0;
							else
								sdaOe_r <= ~bytes_r[byteIdx_r[1:0]][3'(3'h7 - bitIdx_r[2:0])]; // R23 R5
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b1;
						end else if (q_r == 2'h2) begin
							if (bitIdx_r != 4'(pot_pkg::BYTE_BITS))
								rxShift_r <= {rxShift_r[6:0], sdaSync_r[1]}; // R23
							else if (!rxByte && sdaSync_r[1])
								nack_r <= 1'b1; // R9
						end else begin
							scl_r    <= 1'b0;
							bitIdx_r <= 4'(bitIdx_r + 4'h1);
							if (bitIdx_r == 4'(pot_pkg::BYTE_BITS)) begin
								bitIdx_r  <= 4'h0;
								byteIdx_r <= 3'(byteIdx_r + 3'h1);
								if (rxByte && byteIdx_r == 3'h1)
									rspLeft <= rxShift_r[4:0];
								if (rxByte && byteIdx_r == 3'h2)
									rspRight <= rxShift_r[4:0];
								if (nack_r || byteIdx_r == 3'(nBytes_r - 3'h1))
									state_r <= (!nack_r && !readMode_r && nBytes_r == 3'h2
										&& steps_r != 8'h00) ? H_STEP : H_STOP;
							end
						end
					end
					H_STEP: begin
						if (q_r == 2'h0) begin
							sdaOe_r <= ~up_r; // R19
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b1;
						end else if (q_r == 2'h3) begin
							scl_r   <= 1'b0;
							steps_r <= 8'(steps_r - 8'h01);
							if (steps_r == 8'h01)
								state_r <= H_STOP;
						end
					end
					H_STOP: begin
						if (q_r == 2'h0) begin
							sdaOe_r <= 1'b1;
						end else if (q_r == 2'h1) begin
							scl_r <= 1'b1;
						end else if (q_r == 2'h2) begin
							sdaOe_r <= 1'b0; // R7
						end else begin
							state_r  <= H_IDLE;
							rspValid <= 1'b1;
							rspNack  <= nack_r;
						end
					end
					H_IDLE: begin
						q_r <= 2'h0;
					end
					default: begin
						state_r <= H_IDLE;
					end
				endcase
			end
		end
	end
endmodule : pot_host

// >>> tb/pot_link_checker.sv
// Assertions on the two-wire link between the pot host and the pot device.
`timescale 1ns/100ps
module pot_link_checker #(
	parameter logic [4:0] TYPE_ID = pot_pkg::TYPE_ID_DEFAULT  // Type pattern, arbitrary.
) (
	input wire logic clk,          // System clock.
	input wire logic resetn,       // Reset, active low.
	input wire logic scl,          // Serial clock.
	input wire logic hostSdaOe,    // Host pulls data low.
	input wire logic devSdaOe,     // Device pulls data low.
	input wire logic sda,          // Resolved data line.
	input wire logic addrStrapHi,  // Upper strap pin.
	input wire logic addrStrapLo   // Lower strap pin.
);
	logic       sclD;
	logic       sdaD;
	logic       inFrame;
	logic       rdFrame;
	logic       addrOk;
	logic [3:0] bitPos;
	logic [2:0] byteIdx;
	logic [7:0] sh;
	wire        sclRise = scl & ~sclD;
	wire        startC  = scl & sclD & sdaD & ~sda;
	wire        stopC   = scl & sclD & ~sdaD & sda;
	wire        adrHit  = sh[7:1] == {TYPE_ID, addrStrapHi, addrStrapLo};
	wire        insOk   = ~sh[3] & (sh[1:0] != 2'h0)
		& (sh[7:4] == pot_pkg::OP_WRITE | sh[7:4] == pot_pkg::OP_STEP);

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
		end else begin
			sclD <= scl;
			sdaD <= sda;
		end
	end

	// Tracks bit slot and byte number of the current frame.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inFrame <= 1'b0;
			rdFrame <= 1'b0;
			addrOk  <= 1'b0;
			bitPos  <= 4'h0;
			byteIdx <= 3'h0;
			sh      <= 8'h00;
		end else if (startC) begin
			inFrame <= 1'b1;
			rdFrame <= 1'b0;
			addrOk  <= 1'b0;
			bitPos  <= 4'h0;
			byteIdx <= 3'h0;
		end else if (stopC) begin
			inFrame <= 1'b0;
		end else if (sclRise) begin
			sh     <= {sh[6:0], sda};
			bitPos <= (bitPos == 4'h8) ? 4'h0 : bitPos + 4'h1;
			if (bitPos == 4'h8 && byteIdx != 3'h7) begin
				byteIdx <= byteIdx + 3'h1;
			end
			if (bitPos == 4'h8 && byteIdx == 3'h0) begin
				rdFrame <= sh[0];
				addrOk  <= adrHit;
			end
		end
	end

	sequence s_ack_slot;
		sclRise && inFrame && bitPos == 4'h8;
	endsequence

	property p_addr_ack;
		s_ack_slot ##0 byteIdx == 3'h0 |-> devSdaOe == adrHit;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
	property p_instr_ack;
		s_ack_slot ##0 (byteIdx == 3'h1 && addrOk && !rdFrame) |-> devSdaOe == insOk;
	endproperty
	a_instr_ack: assert property (p_instr_ack) else $error("instruction ack wrong");
	property p_host_release;
		s_ack_slot ##0 (byteIdx < 3'h2 && !rdFrame) |-> !hostSdaOe;
	endproperty
	a_host_release: assert property (p_host_release) else $error("host holds ack bit");
	property p_no_drive;
		sclRise && inFrame && !rdFrame && bitPos != 4'h8 |-> !devSdaOe;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("device drives data bit");
	property p_read_pad;
		sclRise && inFrame && rdFrame && addrOk && (byteIdx == 3'h1 || byteIdx == 3'h2)
			&& bitPos < 4'h3 |-> devSdaOe;
	endproperty
	a_read_pad: assert property (p_read_pad) else $error("read pad bit not zero");
	property p_idle_quiet;
		!inFrame || (byteIdx != 3'h0 && !addrOk) |-> !devSdaOe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle device pulls data");
	property p_dev_scl_low;
		$changed(devSdaOe) |-> !scl;
	endproperty
	a_dev_scl_low: assert property (p_dev_scl_low) else $error("device moved data");
	property p_scl_idle;
		!inFrame |-> scl;
	endproperty
	a_scl_idle: assert property (p_scl_idle) else $error("clock low outside frame");
endmodule : pot_link_checker

// >>> tb/testbench.sv
// Self-checking bench joining the pot host and the pot device over the link.
`timescale 1ns/100ps
module testbench;
	logic          clk, resetn, cmdValid, cmdReady, cmdZc, cmdUp, rspValid, rspNack;
	logic          addrStrapHi, addrStrapLo, zeroCross;
	pot_pkg::cmd_t cmdKind;
	logic [1:0]    cmdAddr, cmdSel;
	logic [4:0]    cmdLeft, cmdRight, rspLeft, rspRight, wiperLeft, wiperRight, p;
	logic [7:0]    cmdSteps, attenLeft, attenRight;
	logic [31:0]   tapSelLeft, tapSelRight;
	int            n_errors, checks_done;
	int            pos[8] = '{31, 20, 19, 10, 9, 5, 4, 1};
	pot_link_if link ();
	pot_host #(.QUARTER(8)) pot_host_i (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdAddr(cmdAddr),
		.cmdSel(cmdSel), .cmdZc(cmdZc), .cmdLeft(cmdLeft), .cmdRight(cmdRight),
		.cmdSteps(cmdSteps), .cmdUp(cmdUp), .rspValid(rspValid), .rspNack(rspNack),
		.rspLeft(rspLeft), .rspRight(rspRight));
	pot_device pot_device_i (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
		.addrStrapHi(addrStrapHi), .addrStrapLo(addrStrapLo), .zeroCross(zeroCross),
		.tapSelLeft(tapSelLeft), .tapSelRight(tapSelRight), .attenLeft(attenLeft),
		.attenRight(attenRight), .wiperLeft(wiperLeft), .wiperRight(wiperRight));
	pot_link_checker chk (.clk(clk), .resetn(resetn), .scl(link.scl), .sda(link.sda),
		.hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe),
		.addrStrapHi(addrStrapHi), .addrStrapLo(addrStrapLo));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic run(input pot_pkg::cmd_t k, input logic [1:0] a, input logic [1:0] s,
		input logic z, input logic [4:0] l, input logic [4:0] r, input logic [7:0] n,
		input logic u);
		int i;
		@(negedge clk);
		cmdKind = k;
		cmdAddr = a;
		cmdSel = s;
		cmdZc = z;
		cmdLeft = l;
		cmdRight = r;
		cmdSteps = n;
		cmdUp = u;
		cmdValid = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
		for (i = 0; i < 20000 && rspValid !== 1'b1; i++) @(negedge clk);
		check(rspValid, 1'b1);
		check(cmdReady, 1'b1);
	endtask : run

	function automatic logic [7:0] db(input int n);
		if (n >= 20) return 8'(n - 31);
		if (n >= 10) return 8'(2 * n - 51);
		if (n >= 5) return 8'(3 * n - 61);
		if (n >= 1) return 8'(4 * n - 66);
		return pot_pkg::MUTE_DB;
	endfunction : db

	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (50000) @(posedge clk);
		n_errors++;
		results();
	end

	initial begin
		{resetn, cmdValid, cmdZc, cmdUp, addrStrapHi, addrStrapLo, zeroCross} = 7'h00;
		cmdKind = pot_pkg::CMD_WRITE;
		{cmdAddr, cmdSel, cmdLeft, cmdRight, cmdSteps} = '0;
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		check({wiperLeft, wiperRight}, 10'h000);
		check(tapSelRight, 32'h1);
		check(attenLeft, pot_pkg::MUTE_DB);
		foreach (pos[i]) begin
			p = 5'(pos[i]);
			run(pot_pkg::CMD_WRITE, 2'h0, 2'h3, 1'b0, p, 5'h1F - p, 8'h00, 1'b0);
			check({wiperLeft, wiperRight}, {p, 5'h1F - p});
			check(tapSelLeft, 32'h1 << p);
			check(attenLeft, db(pos[i]));
			check(tapSelRight, 32'h1 << (5'h1F - p));
			check(attenRight, db(31 - pos[i]));
			check(rspNack, 1'b0);
		end
		run(pot_pkg::CMD_WRITE, 2'h0, 2'h3, 1'b0, 5'h13, 5'h0C, 8'h00, 1'b0);
		run(pot_pkg::CMD_READ, 2'h0, 2'h3, 1'b0, 5'h00, 5'h00, 8'h00, 1'b0);
		check({rspLeft, rspRight}, {5'h13, 5'h0C});
		run(pot_pkg::CMD_WRITE, 2'h0, 2'h1, 1'b0, 5'h1D, 5'h00, 8'h00, 1'b0);
		check({wiperLeft, wiperRight}, {5'h1D, 5'h0C});
		run(pot_pkg::CMD_WRITE, 2'h0, 2'h2, 1'b0, 5'h00, 5'h01, 8'h00, 1'b0);
		check({wiperLeft, wiperRight}, {5'h1D, 5'h01});
		run(pot_pkg::CMD_STEP, 2'h0, 2'h3, 1'b0, 5'h00, 5'h00, 8'h05, 1'b1);
		check({wiperLeft, wiperRight}, {5'h1F, 5'h06});
		run(pot_pkg::CMD_STEP, 2'h0, 2'h2, 1'b0, 5'h00, 5'h00, 8'h08, 1'b0);
		check({wiperLeft, wiperRight}, {5'h1F, 5'h00});
		run(pot_pkg::CMD_WRITE, 2'h2, 2'h3, 1'b0, 5'h0A, 5'h0A, 8'h00, 1'b0);
		check({rspNack, wiperLeft, wiperRight}, {1'b1, 5'h1F, 5'h00});
		addrStrapHi = 1'b1;
		run(pot_pkg::CMD_WRITE, 2'h2, 2'h1, 1'b0, 5'h0A, 5'h00, 8'h00, 1'b0);
		check({rspNack, wiperLeft}, {1'b0, 5'h0A});
		run(pot_pkg::CMD_WRITE, 2'h2, 2'h0, 1'b0, 5'h11, 5'h11, 8'h00, 1'b0);
		check({rspNack, wiperLeft}, {1'b1, 5'h0A});
		run(pot_pkg::CMD_WRITE, 2'h2, 2'h1, 1'b1, 5'h03, 5'h00, 8'h00, 1'b0);
		check(wiperLeft, 5'h0A);
		zeroCross = 1'b1;
		repeat (8) @(negedge clk);
		check(wiperLeft, 5'h03);
		results();
	end
endmodule : testbench
